// ---- core/psm_pkg.sv ----
// Shared constants and types for the program space address mapper.
// Assumes a single 40 MHz core clock and a synchronous active-low reset.
package psm_pkg;

    // Address and data widths
    localparam int PSM_PADDR_W = 24;
    localparam int PSM_PWORD_W = 24;
    localparam int PSM_DATA_W  = 16;
    localparam int PSM_PAGE_W  = 8;

    // Field positions
    localparam int PSM_CFG_BIT = 23;
    localparam int PSM_EA_MSB  = 15;

    // Program byte write masks, bit 0 covers program bits 7:0
    localparam logic [2:0] PSM_MASK_LO_WORD = 3'h3;
    localparam logic [2:0] PSM_MASK_LO_B0   = 3'h1;
    localparam logic [2:0] PSM_MASK_LO_B1   = 3'h2;
    localparam logic [2:0] PSM_MASK_HI      = 3'h4;
    localparam logic [2:0] PSM_MASK_NONE    = 3'h0;

    // Extra instruction cycles for window accesses
    localparam logic [1:0] PSM_PEN_NONE  = 2'h0;
    localparam logic [1:0] PSM_PEN_SHORT = 2'h1;
    localparam logic [1:0] PSM_PEN_LONG  = 2'h2;
    localparam logic [1:0] PSM_PEN_EDGE  = 2'h2;

    // Reset values
    localparam logic [23:0] PSM_ADDR_RST = 24'h000000;
    localparam logic [15:0] PSM_DATA_RST = 16'h0000;

    // Kind of access offered by the core
    typedef enum logic [2:0] {
        PSM_K_FETCH = 3'h0,
        PSM_K_RDL   = 3'h1,
        PSM_K_RDH   = 3'h2,
        PSM_K_WTL   = 3'h3,
        PSM_K_WTH   = 3'h4,
        PSM_K_DATA  = 3'h5
    } psm_kind_t;

    // Access sequencer states
    typedef enum logic [3:0] {
        PSM_ST_IDLE = 4'h1,
        PSM_ST_ADDR = 4'h2,
        PSM_ST_DATA = 4'h4,
        PSM_ST_PEN  = 4'h8
    } psm_state_t;

endpackage

// ---- core/psm_lane_if.sv ----
// Carrier between the sequencer and the read lane steering.
// Assumes the steering is purely combinational.
`timescale 1ns/1ps
`default_nettype none
interface psm_lane_if;
    logic [23:0] word;      // Program word returned by memory
    logic        high;      // High-part table read
    logic        byte_op;   // Byte-sized read
    logic        byte_sel;  // Byte select address bit
    logic [15:0] data;      // Steered data result

    modport steer (input word, high, byte_op, byte_sel, output data);
    modport core  (output word, high, byte_op, byte_sel, input data);
endinterface
`default_nettype wire

// ---- core/psm_lane_steer.sv ----
// Read lane steering from a 24-bit program word to 16-bit data.
// Assumes the word input is stable during the capture cycle.
`timescale 1ns/1ps
`default_nettype none
module psm_lane_steer (
    psm_lane_if.steer lane
);
    import psm_pkg::*;

    wire logic [7:0]  lo_byte;
    wire logic [7:0]  hi_byte;
    wire logic [15:0] lo_path;
    wire logic [15:0] hi_path;

    // RL5 low byte select
    assign lo_byte = lane.byte_sel ? lane.word[15:8] : lane.word[7:0];
    // RL4 low word unchanged
    assign lo_path = lane.byte_op ? {8'h00, lo_byte} : lane.word[15:0];
    // RL7 phantom zero byte
    assign hi_byte = (lane.byte_op && lane.byte_sel) ? 8'h00
                                                     : lane.word[23:16];
    // RL6 upper byte zero
    assign hi_path = {8'h00, hi_byte};

    // RL8 two parallel spaces
    assign lane.data = lane.high ? hi_path : lo_path;

endmodule // psm_lane_steer
`default_nettype wire

// ---- core/psm_mapper.sv ----
// Program space address mapper: builds program addresses for fetch,
// table and window accesses, steers read lanes and adds window stalls.
// Assumes a synchronous program memory that returns read data in the
// cycle after its read strobe, and a core that holds off new requests
// while ready is low.
`timescale 1ns/1ps
`default_nettype none
// Operation
// RL1 - 24-bit program address, words step by two, bit zero clear
// RL2 - Non-table accesses stay in user half; table page bit 7 picks space
// RL3 - Address bit 23 only set by table access to configuration space
// RL4 - Word low table read returns program bits 15:0 unchanged
// RL5 - Byte low table read picks bits 7:0 or 15:8 by byte select
// RL6 - Word high table read gives bits 23:16 low, upper byte zero
// RL7 - Byte high table read gives bits 23:16, or zero byte when select set
// RL8 - Low table ops reach low word, high ops reach upper byte
// RL9 - Data access goes to program memory when EA msb and enable set
// RL10 - Window address from EA low 15 bits plus window page, bit 23 zero
// RL11 - Window read delivers only low 16 bits of program word
// RL12 - Table access suspends window mapping
// RL13 - Outside loop, short class window access costs one extra cycle
// RL14 - Outside loop, other window access costs two extra cycles
// RL15 - In loop, first, last, interrupt exit, re-entry cost two extra
// RL16 - Other loop iterations execute window access in a single cycle
// RL17 - Table address is table page over data effective address
module psm_mapper (
    input  wire logic                ref_clk_i,
    input  wire logic                rst_n_i,
    input  wire logic                req_valid_i,
    input  wire psm_pkg::psm_kind_t  req_kind_i,
    input  wire logic                req_byte_i,
    input  wire logic                req_short_class_i,
    input  wire logic [15:0]         effective_address_i,
    input  wire logic [22:0]         program_counter_i,
    input  wire logic [15:0]         wdata_i,
    input  wire logic [7:0]          table_page_register_i,
    input  wire logic [7:0]          visibility_page_register_i,
    input  wire logic                visibility_enable_i,
    input  wire logic                loop_active_i,
    input  wire logic                loop_first_i,
    input  wire logic                loop_last_i,
    input  wire logic                loop_irq_exit_i,
    input  wire logic                loop_reentry_i,
    input  wire logic [23:0]         pm_rdata_i,
    output logic                     req_ready_o,
    output logic [23:0]              pm_addr_o,
    output logic                     pm_rd_o,
    output logic                     pm_wr_o,
    output logic [2:0]               pm_wmask_o,
    output logic [23:0]              pm_wdata_o,
    output logic [15:0]              rd_data_o,
    output logic                     done_o,
    output logic                     stall_o
);
    import psm_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Decode helpers

    // Stall cost of one window access
    function automatic logic [1:0] psm_penalty(
        input logic short_c,
        input logic in_loop,
        input logic edge_it
    );
        logic [1:0] pen;
        pen = PSM_PEN_NONE;
        if (in_loop) begin
            pen = edge_it ? PSM_PEN_EDGE : PSM_PEN_NONE;
        end else begin
            pen = short_c ? PSM_PEN_SHORT : PSM_PEN_LONG;
        end
        return pen;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // State

    psm_state_t  state_reg;
    psm_state_t  state_next;
    psm_kind_t   kind_reg;
    logic        byte_reg;
    logic        bsel_reg;
    logic [1:0]  pen_reg;
    logic [1:0]  cnt_reg;
    logic        ready_reg;
    logic [23:0] addr_reg;
    logic        rd_reg;
    logic        wr_reg;
    logic [2:0]  mask_reg;
    logic [23:0] wdata_reg;
    logic [15:0] rdata_reg;
    logic        done_reg;
    logic        stall_reg;

    ////////////////////////////////////////////////////////////////////
    // Request decode

    wire logic        is_table;
    wire logic        is_write;
    wire logic        is_data;
    wire logic        vis_hit;
    wire logic        accept;
    wire logic        loop_edge;
    wire logic [1:0]  pen_req;
    wire logic [23:0] addr_fetch;
    wire logic [23:0] addr_table;
    wire logic [23:0] addr_vis;
    wire logic [23:0] addr_sel;
    wire logic [2:0]  mask_sel;
    wire logic [23:0] wdata_sel;
    wire logic [15:0] wd_lane;

    assign is_table = (req_kind_i == PSM_K_RDL) || (req_kind_i == PSM_K_RDH)
                   || (req_kind_i == PSM_K_WTL) || (req_kind_i == PSM_K_WTH);
    assign is_write = (req_kind_i == PSM_K_WTL) || (req_kind_i == PSM_K_WTH);
    assign is_data  = (req_kind_i == PSM_K_DATA);

    // RL9 window gate on EA msb and enable
    // RL12 a table access never takes the window
    assign vis_hit = is_data && !is_table && visibility_enable_i
                  && effective_address_i[PSM_EA_MSB];

    // Unmapped data accesses are left to the data space, not answered here
    assign accept = req_valid_i && ready_reg && (!is_data || vis_hit);

    // RL1 word fetch steps by two
    // RL3 fetch keeps bit 23 clear
    assign addr_fetch = {1'b0, program_counter_i[22:1], 1'b0};
    // RL17 table page over effective address
    // RL2 table page bit 7 selects configuration space
    assign addr_table = {table_page_register_i, effective_address_i};
    // RL10 window page over low 15 EA bits
    assign addr_vis   = {1'b0, visibility_page_register_i,
                         effective_address_i[14:0]};

    assign addr_sel = is_table ? addr_table
                    : is_data  ? addr_vis : addr_fetch;

    // RL8 low writes hit low word, high writes the upper byte
    assign mask_sel =
        (req_kind_i == PSM_K_WTL) ?
            (!req_byte_i ? PSM_MASK_LO_WORD
             : effective_address_i[0] ? PSM_MASK_LO_B1 : PSM_MASK_LO_B0)
      : (req_kind_i == PSM_K_WTH) ?
            ((req_byte_i && effective_address_i[0]) ? PSM_MASK_NONE
                                                    : PSM_MASK_HI)
      : PSM_MASK_NONE;

    // Byte writes carry their byte in the low lane; copy it to both halves
    assign wd_lane   = req_byte_i ? {wdata_i[7:0], wdata_i[7:0]} : wdata_i;
    assign wdata_sel = {wdata_i[7:0], wd_lane};

    // RL15 loop edge iterations
    assign loop_edge = loop_first_i || loop_last_i || loop_irq_exit_i
                    || loop_reentry_i;
    // RL13 RL14 RL16 window stall cost
    assign pen_req = vis_hit ? psm_penalty(req_short_class_i,
                                           loop_active_i, loop_edge)
                             : PSM_PEN_NONE;

    ////////////////////////////////////////////////////////////////////
    // Read lane steering

    psm_lane_if lane ();

    assign lane.word     = pm_rdata_i;
    assign lane.high     = (kind_reg == PSM_K_RDH);
    // RL11 window reads use the low word only
    assign lane.byte_op  = byte_reg && (kind_reg != PSM_K_DATA);
    assign lane.byte_sel = bsel_reg;

    psm_lane_steer u_steer (
        .lane (lane.steer)
    );

    ////////////////////////////////////////////////////////////////////
    // Sequencer next state

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            PSM_ST_IDLE: begin
                if (accept) begin
                    state_next = PSM_ST_ADDR;
                end
            end
            PSM_ST_ADDR: state_next = PSM_ST_DATA;
            PSM_ST_DATA: begin
                state_next = (pen_reg == PSM_PEN_NONE) ? PSM_ST_IDLE
                                                       : PSM_ST_PEN;
            end
            PSM_ST_PEN: begin
                if (cnt_reg == 2'h1) begin
                    state_next = PSM_ST_IDLE;
                end
            end
            default: state_next = PSM_ST_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Sequencer and handshake flops

    // Ready and stall are registered, so they lead the state by nothing
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            state_reg <= PSM_ST_IDLE;
            ready_reg <= 1'b0;
            stall_reg <= 1'b0;
            done_reg  <= 1'b0;
            cnt_reg   <= PSM_PEN_NONE;
        end else begin
            state_reg <= state_next;
            ready_reg <= (state_next == PSM_ST_IDLE);
            stall_reg <= (state_next != PSM_ST_IDLE);
            done_reg  <= (state_reg != PSM_ST_IDLE)
                      && (state_next == PSM_ST_IDLE);
            if (state_reg == PSM_ST_DATA) begin
                cnt_reg <= pen_reg;
            end else if (state_reg == PSM_ST_PEN) begin
                cnt_reg <= cnt_reg - 2'h1;
            end
        end
    end

    // Request capture and memory strobes, one cycle wide
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            kind_reg  <= PSM_K_FETCH;
            byte_reg  <= 1'b0;
            bsel_reg  <= 1'b0;
            pen_reg   <= PSM_PEN_NONE;
            addr_reg  <= PSM_ADDR_RST;
            rd_reg    <= 1'b0;
            wr_reg    <= 1'b0;
            mask_reg  <= PSM_MASK_NONE;
            wdata_reg <= PSM_ADDR_RST;
        end else begin
            rd_reg <= accept && !is_write;
            wr_reg <= accept && is_write;
            if (accept) begin
                kind_reg  <= req_kind_i;
                byte_reg  <= req_byte_i;
                bsel_reg  <= effective_address_i[0];
                pen_reg   <= pen_req;
                addr_reg  <= addr_sel;
                mask_reg  <= mask_sel;
                wdata_reg <= wdata_sel;
            end
        end
    end

    // Read result capture while memory data is valid
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            rdata_reg <= PSM_DATA_RST;
        end else if (state_reg == PSM_ST_DATA && !wr_reg
                     && kind_reg != PSM_K_WTL && kind_reg != PSM_K_WTH) begin
            rdata_reg <= lane.data;
        end
    end

    assign req_ready_o = ready_reg;
    assign pm_addr_o   = addr_reg;
    assign pm_rd_o     = rd_reg;
    assign pm_wr_o     = wr_reg;
    assign pm_wmask_o  = mask_reg;
    assign pm_wdata_o  = wdata_reg;
    assign rd_data_o   = rdata_reg;
    assign done_o      = done_reg;
    assign stall_o     = stall_reg;

    ////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    wire logic in_data;
    assign in_data = (state_reg == PSM_ST_DATA);

    chk_fetch_align: assert property ( // RL1
        accept && req_kind_i == PSM_K_FETCH
        |=> pm_rd_o && !pm_addr_o[0]
            && pm_addr_o[22:1] == $past(program_counter_i[22:1]))
        else $error("fetch address misformed");

    chk_user_bit23: assert property ( // RL3
        (pm_rd_o || pm_wr_o)
        && (kind_reg == PSM_K_FETCH || kind_reg == PSM_K_DATA)
        |-> !pm_addr_o[PSM_CFG_BIT])
        else $error("bit 23 set outside table access");

    chk_table_addr: assert property ( // RL17
        accept && is_table
        |=> pm_addr_o == {$past(table_page_register_i),
                          $past(effective_address_i)})
        else $error("table address misformed");

    chk_table_space: assert property ( // RL2
        accept && is_table
        |=> pm_addr_o[PSM_CFG_BIT] == $past(table_page_register_i[7]))
        else $error("table space select wrong");

    chk_table_nowin: assert property ( // RL12
        accept && is_table && visibility_enable_i
        && effective_address_i[PSM_EA_MSB]
        |=> pm_addr_o[15] == $past(effective_address_i[15]))
        else $error("window remapped a table access");

    chk_win_gate: assert property ( // RL9
        req_valid_i && ready_reg && is_data
        && !(visibility_enable_i && effective_address_i[PSM_EA_MSB])
        |=> !pm_rd_o && !pm_wr_o)
        else $error("unmapped data access reached memory");

    chk_win_addr: assert property ( // RL10
        accept && is_data
        |=> pm_addr_o == {1'b0, $past(visibility_page_register_i),
                          $past(effective_address_i[14:0])})
        else $error("window address misformed");

    chk_rdl_word: assert property ( // RL4
        in_data && kind_reg == PSM_K_RDL && !byte_reg
        |=> rd_data_o == $past(pm_rdata_i[15:0]))
        else $error("low word read wrong");

    chk_rdl_byte: assert property ( // RL5
        in_data && kind_reg == PSM_K_RDL && byte_reg
        |=> rd_data_o[7:0] == ($past(bsel_reg) ? $past(pm_rdata_i[15:8])
                                               : $past(pm_rdata_i[7:0])))
        else $error("low byte read wrong");

    chk_rdh_word: assert property ( // RL6
        in_data && kind_reg == PSM_K_RDH && !byte_reg
        |=> rd_data_o == {8'h00, $past(pm_rdata_i[23:16])})
        else $error("high word read wrong");

    chk_rdh_byte: assert property ( // RL7
        in_data && kind_reg == PSM_K_RDH && byte_reg
        |=> rd_data_o[7:0] == ($past(bsel_reg) ? 8'h00
                                               : $past(pm_rdata_i[23:16])))
        else $error("high byte read wrong");

    chk_win_read: assert property ( // RL11
        in_data && kind_reg == PSM_K_DATA
        |=> rd_data_o == $past(pm_rdata_i[15:0]))
        else $error("window read not low word");

    chk_high_write: assert property ( // RL8
        accept && req_kind_i == PSM_K_WTH && !req_byte_i
        |=> pm_wr_o && pm_wmask_o == PSM_MASK_HI)
        else $error("high write mask wrong");

    chk_pen_short: assert property ( // RL13
        accept && vis_hit && !loop_active_i && req_short_class_i
        |=> ##2 state_reg == PSM_ST_PEN ##1 done_o)
        else $error("short class window stall not one cycle");

    chk_pen_long: assert property ( // RL14
        accept && vis_hit && !loop_active_i && !req_short_class_i
        |=> ##2 (state_reg == PSM_ST_PEN) [*2] ##1 done_o)
        else $error("window stall not two cycles");

    chk_loop_edge: assert property ( // RL15
        accept && vis_hit && loop_active_i && loop_edge
        |=> ##2 (state_reg == PSM_ST_PEN) [*2] ##1 done_o)
        else $error("loop edge stall not two cycles");

    chk_loop_single: assert property ( // RL16
        accept && vis_hit && loop_active_i && !loop_edge
        |=> ##2 done_o)
        else $error("loop window access stalled");

    cov_table_cfg: cover property (
        accept && is_table && table_page_register_i[7]);
    cov_win_long: cover property (
        accept && vis_hit && !loop_active_i && !req_short_class_i);
    cov_loop_fast: cover property (
        accept && vis_hit && loop_active_i && !loop_edge);
    cov_phantom: cover property (
        in_data && kind_reg == PSM_K_RDH && byte_reg && bsel_reg);

endmodule // psm_mapper
`default_nettype wire

// ---- verif/psm_prog_mem.sv ----
// Behavioural program memory on the far side of the mapper.
// Assumes one-cycle read latency after the mapper's read strobe.
`timescale 1ns/1ps
`default_nettype none
module psm_prog_mem (
    input  wire logic        clk_i,
    input  wire logic [23:0] addr_i,
    input  wire logic        rd_i,
    input  wire logic        wr_i,
    input  wire logic [2:0]  wmask_i,
    input  wire logic [23:0] wdata_i,
    output logic      [23:0] rdata_o
);
    logic [23:0] mem [0:255];
    int          i;
    //////////////////////////////////////////////////////////////////////
    // Distinct bytes in every lane so a lane mix-up shows at once
    initial begin
        rdata_o = 24'h000000;
        for (i = 0; i < 256; i++) begin
            mem[i] = {8'(i) ^ 8'h5A, ~8'(i), 8'(i)};
        end
    end
    // Read data is only valid one cycle; otherwise it toggles so stale
    // values never pass for fresh ones
    always @(posedge clk_i) begin
        rdata_o <= rd_i ? mem[addr_i[8:1]] : ~rdata_o;
        for (int b = 0; b < 3; b++) begin
            if (wr_i && wmask_i[b]) begin
                mem[addr_i[8:1]][b*8 +: 8] <= wdata_i[b*8 +: 8];
            end
        end
    end
endmodule // psm_prog_mem
`default_nettype wire

// ---- verif/test_psm_mapper.sv ----
// Self-checking bench for the program space address mapper.
// Assumes the mapper's hand-over timing: done in cycle 3 to 5, counting
// the request cycle whose closing edge takes the access as cycle 0.
`timescale 1ns/1ps
`default_nettype none
module test_psm_mapper;
    import psm_pkg::*;
    logic        ref_clk_i, rst_n_i, req_valid_i, req_byte_i;
    logic        req_short_class_i, visibility_enable_i;
    logic        loop_active_i, loop_first_i, loop_last_i;
    logic        loop_irq_exit_i, loop_reentry_i;
    psm_kind_t   req_kind_i;
    logic [15:0] effective_address_i, wdata_i, rd_data_o;
    logic [22:0] program_counter_i;
    logic [7:0]  table_page_register_i, visibility_page_register_i;
    logic [23:0] pm_rdata_i, pm_addr_o, pm_wdata_o, gaddr;
    logic        req_ready_o, pm_rd_o, pm_wr_o, done_o, stall_o;
    logic [2:0]  pm_wmask_o;
    logic [15:0] got;
    int          n_errors, num_checks, lat;

    psm_mapper dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .req_valid_i(req_valid_i), .req_kind_i(req_kind_i),
        .req_byte_i(req_byte_i), .req_short_class_i(req_short_class_i),
        .effective_address_i(effective_address_i),
        .program_counter_i(program_counter_i), .wdata_i(wdata_i),
        .table_page_register_i(table_page_register_i),
        .visibility_page_register_i(visibility_page_register_i),
        .visibility_enable_i(visibility_enable_i),
        .loop_active_i(loop_active_i), .loop_first_i(loop_first_i),
        .loop_last_i(loop_last_i), .loop_irq_exit_i(loop_irq_exit_i),
        .loop_reentry_i(loop_reentry_i), .pm_rdata_i(pm_rdata_i),
        .req_ready_o(req_ready_o), .pm_addr_o(pm_addr_o),
        .pm_rd_o(pm_rd_o), .pm_wr_o(pm_wr_o), .pm_wmask_o(pm_wmask_o),
        .pm_wdata_o(pm_wdata_o), .rd_data_o(rd_data_o),
        .done_o(done_o), .stall_o(stall_o));
    psm_prog_mem mem (.clk_i(ref_clk_i), .addr_i(pm_addr_o),
        .rd_i(pm_rd_o), .wr_i(pm_wr_o), .wmask_i(pm_wmask_o),
        .wdata_i(pm_wdata_o), .rdata_o(pm_rdata_i));
    //////////////////////////////////////////////////////////////////////
    // 40 MHz core clock
    initial begin
        ref_clk_i = 1'b0;
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end
    // Expected memory contents, same fill as the memory model
    function automatic logic [23:0] pat(input logic [7:0] i);
        return {i ^ 8'h5A, ~i, i};
    endfunction
    task automatic close_out();
        if (n_errors == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic bail();
        n_errors++;
        close_out();
    endtask
    // One access; counts cycles from the taking edge to done
    task automatic acc(input psm_kind_t k, input logic [15:0] ea,
        input logic b, input logic s, input logic [4:0] lp, input int want);
        int n;
        for (n = 0; req_ready_o !== 1'b1; n++) begin
            if (n > 20) bail();
            @(negedge ref_clk_i);
        end
        req_kind_i = k;
        effective_address_i = ea;
        req_byte_i = b;
        req_short_class_i = s;
        {loop_active_i, loop_first_i, loop_last_i} = lp[4:2];
        {loop_irq_exit_i, loop_reentry_i} = lp[1:0];
        req_valid_i = 1'b1;
        @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        req_valid_i = 1'b0;
        lat = 0;
        for (n = 1; n < 9 && lat == 0; n++) begin
            @(posedge ref_clk_i);
            #1;
            // Edge n after the take opens cycle n + 1 of the access
            if (done_o === 1'b1) lat = n + 1;
            else check(stall_o, want != 0);
        end
        gaddr = pm_addr_o;
        got = rd_data_o;
        if (lat == 0 && want != 0) bail();
        check(lat, want);
        check({stall_o, req_ready_o}, 2'b01);
        @(negedge ref_clk_i);
    endtask
    // Fetch with odd PC and bit 22 set
    task automatic run_fetch();
        program_counter_i = 23'h46ABCD;
        acc(PSM_K_FETCH, 16'h0000, 1'b0, 1'b0, 5'h00, 3);
        check(gaddr, {1'b0, program_counter_i[22:1], 1'b0});
        check(got, pat(program_counter_i[8:1]) & 24'hFFFF);
    endtask
    // Table reads with the window also enabled and EA msb set
    task automatic run_table();
        logic [23:0] w;
        w = pat(8'h23);
        table_page_register_i = 8'h81;
        acc(PSM_K_RDL, 16'h8046, 1'b0, 1'b0, 5'h00, 3);
        check(gaddr, 24'h818046);
        check(got, w[15:0]);
        acc(PSM_K_RDL, 16'h8046, 1'b1, 1'b0, 5'h00, 3);
        check(got[7:0], w[7:0]);
        acc(PSM_K_RDL, 16'h8047, 1'b1, 1'b0, 5'h00, 3);
        check(got[7:0], w[15:8]);
        acc(PSM_K_RDH, 16'h8046, 1'b0, 1'b0, 5'h00, 3);
        check(got, {8'h00, w[23:16]});
        acc(PSM_K_RDH, 16'h8046, 1'b1, 1'b0, 5'h00, 3);
        check(got[7:0], w[23:16]);
        acc(PSM_K_RDH, 16'h8047, 1'b1, 1'b0, 5'h00, 3);
        check(got[7:0], 8'h00);
        table_page_register_i = 8'h01;
        acc(PSM_K_RDL, 16'h8046, 1'b0, 1'b0, 5'h00, 3);
        check(gaddr, 24'h018046);
    endtask
    // Window reads outside and inside loops, then refused accesses
    task automatic run_window();
        acc(PSM_K_DATA, 16'hC0F2, 1'b0, 1'b1, 5'h00, 4);
        check(gaddr, {1'b0, 8'h3C, 15'h40F2});
        check(got, pat(8'h79) & 24'hFFFF);
        acc(PSM_K_DATA, 16'hC0F2, 1'b0, 1'b0, 5'h00, 5);
        acc(PSM_K_DATA, 16'hC0F2, 1'b0, 1'b1, 5'h10, 3);
        for (int j = 0; j < 4; j++) begin
            acc(PSM_K_DATA, 16'hC0F2, 1'b0, 1'b1, 5'h10 | (5'h1 << j), 5);
        end
        visibility_enable_i = 1'b0;
        acc(PSM_K_DATA, 16'hC0F2, 1'b0, 1'b0, 5'h00, 0);
        visibility_enable_i = 1'b1;
        acc(PSM_K_DATA, 16'h40F2, 1'b0, 1'b0, 5'h00, 0);
    endtask
    // Writes to both halves, read back through the table path
    task automatic run_write();
        wdata_i = 16'h1357;
        acc(PSM_K_WTL, 16'h8010, 1'b0, 1'b0, 5'h00, 3);
        acc(PSM_K_RDL, 16'h8010, 1'b0, 1'b0, 5'h00, 3);
        check(got, 16'h1357);
        wdata_i = 16'h00C3;
        acc(PSM_K_WTL, 16'h8011, 1'b1, 1'b0, 5'h00, 3);
        acc(PSM_K_RDL, 16'h8010, 1'b0, 1'b0, 5'h00, 3);
        check(got, 16'hC357);
        wdata_i = 16'h00EE;
        acc(PSM_K_WTH, 16'h8011, 1'b1, 1'b0, 5'h00, 3);
        acc(PSM_K_RDH, 16'h8010, 1'b0, 1'b0, 5'h00, 3);
        check(got, {8'h00, 8'h08 ^ 8'h5A});
        wdata_i = 16'h0099;
        acc(PSM_K_WTH, 16'h8010, 1'b0, 1'b0, 5'h00, 3);
        acc(PSM_K_RDH, 16'h8010, 1'b0, 1'b0, 5'h00, 3);
        check(got, 16'h0099);
    endtask
    // Reset for six cycles, then every scenario in turn
    initial begin
        n_errors = 0;
        num_checks = 0;
        rst_n_i = 1'b0;
        req_valid_i = 1'b0;
        req_kind_i = PSM_K_FETCH;
        {req_byte_i, req_short_class_i} = 2'h0;
        {loop_active_i, loop_first_i, loop_last_i} = 3'h0;
        {loop_irq_exit_i, loop_reentry_i} = 2'h0;
        effective_address_i = 16'h0000;
        program_counter_i = 23'h000000;
        wdata_i = 16'h0000;
        table_page_register_i = 8'h00;
        visibility_page_register_i = 8'h3C;
        visibility_enable_i = 1'b1;
        repeat (6) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        rst_n_i = 1'b1;
        run_fetch();
        run_table();
        run_window();
        run_write();
        close_out();
    end
endmodule // test_psm_mapper
`default_nettype wire
